// *** logic/sar_seq.sv ***
// Purpose: digital control of a 12-bit sar converter with 8-channel sequencer
// Assumes: sar_cmp comes from the converter's comparator, clocked with clk
// Notes:   results leave through per-channel buffers and a two-entry stream
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Function
// - at most 18 MHz, at least 18 clocks
// - acquisition window length is programmable
// - eight-input sequencer selects converter input
// - autonomous scan, no idle between channels while the stream buffer has room
// - state machine scan or firmware channel select
// - separate result buffer for every channel
// - per-channel sample time applied on conversion
// - out-of-range request raised per result immediately
// - no operation during deep low-power mode
// - clock off in sleep, 35 us wake
module sar_seq #(
  parameter int CONV_DIV = 1   // system clocks per conversion clock
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // avalon-mm register slave
  input  wire logic [7:0]                  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic [31:0]                      avs_readdata,
  output logic                             avs_waitrequest,
  // power control
  input  wire logic                        deep_sleep,
  output logic                             sar_ready,
  // analog front end
  input  wire logic                        sar_cmp,
  output logic [2:0]                       sar_mux_sel,
  output logic                             sar_sample,
  output logic [sar_pkg::RES_BITS-1:0]     sar_dac,
  // result stream
  output logic                             res_valid,
  input  wire logic                        res_ready,
  output logic [2:0]                       res_chan,
  output logic [sar_pkg::RES_BITS-1:0]     res_data,
  // event requests
  output logic                             scan_done_irq,
  output logic                             range_irq
);
  import sar_pkg::*;

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (CONV_DIV < 1 || CONV_DIV > 65535) begin : g_bad_div
    $error("CONV_DIV must lie in 1..65535");
  end
  if (CLK_HZ / CONV_DIV > CONV_HZ_MAX) begin : g_fast_div
    $error("conversion clock above its ceiling");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    sar_state_t         st;       // sequencer state
    logic [8:0]         wcnt;     // wake-up countdown
    logic [15:0]        div;      // conversion clock divider
    logic [7:0]         scnt;     // sample window countdown
    logic [3:0]         bitn;     // bit under trial
    logic [11:0]        code;     // trial code driven to the dac
    logic [2:0]         ch;       // channel in work or next in scan
    logic               en;       // block enable
    logic               auto_md;  // scan by state machine
    logic               cont;     // repeat scans
    logic               run;      // scan request pending
    logic [2:0]         man_ch;   // firmware channel
    logic [7:0]         chen;     // enabled channels
    logic [11:0]        lo;       // low limit
    logic [11:0]        hi;       // high limit
    logic [7:0][7:0]    stime;    // sample time per channel
    logic [7:0][11:0]   res;      // result buffer per channel
    logic [7:0]         rvalid;   // unread result per channel
    logic [7:0]         rflag;    // sticky out-of-range per channel
    logic               done;     // sticky scan done
    logic [1:0][14:0]   fq;       // stream buffer, entry 0 is head
    logic [1:0]         fcnt;     // stream buffer fill
    logic               ack;      // bus answer cycle
    logic [31:0]        rdata;    // read data held for the answer
  } sar_st_t;

  sar_st_t s;       // registered state
  sar_st_t next_s;  // next state

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // next enabled channel after cur; wrap set when scan order restarts
  function automatic logic [3:0] next_chan(input logic [7:0] en, input logic [2:0] cur);
    logic [2:0] c;
    logic       found;
    next_chan = {1'b0, cur};
    found     = 1'b0;
    for (int i = 1; i <= NUM_CHAN; i++) begin
      c = 3'(cur + 3'(i));
      if (!found && en[c]) begin
        found     = 1'b1;
        next_chan = {(c <= cur), c};
      end
    end
  endfunction

  // sample window length, never shorter than the conversion floor needs
  function automatic logic [7:0] samp_len(input logic [7:0] t);
    samp_len = (t < 8'(MIN_SAMPLE)) ? 8'(MIN_SAMPLE) : t;
  endfunction

  // register read view
  function automatic logic [31:0] rd_word(input sar_st_t r, input logic [7:0] a);
    rd_word = 32'h0000_0000;
    if (a == OFS_CTRL) begin
      rd_word[CTRL_EN]                  = r.en;
      rd_word[CTRL_AUTO]                = r.auto_md;
      rd_word[CTRL_CONT]                = r.cont;
      rd_word[CTRL_CH_LO+2:CTRL_CH_LO]  = r.man_ch;
    end else if (a == OFS_CHEN) begin
      rd_word[7:0] = r.chen;
    end else if (a == OFS_STAT) begin
      rd_word[STAT_BUSY]  = (r.st == S_SAMPLE) || (r.st == S_CONV);
      rd_word[STAT_READY] = (r.st != S_OFF) && (r.st != S_WAKE);
      rd_word[STAT_DONE]  = r.done;
      rd_word[STAT_RUN]   = r.run;
      rd_word[STAT_FCNT_LO+1:STAT_FCNT_LO] = r.fcnt;
    end else if (a == OFS_LIMLO) begin
      rd_word[11:0] = r.lo;
    end else if (a == OFS_LIMHI) begin
      rd_word[11:0] = r.hi;
    end else if (a == OFS_RANGE) begin
      rd_word[7:0] = r.rflag;
    end else if (a[7:5] == OFS_STIME[7:5] && a[1:0] == 2'b00) begin
      rd_word[7:0] = r.stime[a[4:2]];
    end else if (a[7:5] == OFS_RES[7:5] && a[1:0] == 2'b00) begin
      rd_word[11:0]      = r.res[a[4:2]];
      rd_word[RES_VALID] = r.rvalid[a[4:2]];
    end
  endfunction

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic [31:0] wd;     // write data merged by byte enables
    logic [3:0]  nc;     // next channel with wrap flag
    logic [11:0] kept;   // code after deciding the trial bit
    logic        tick;   // conversion clock enable
    logic        go;     // start the next sample at once
    wd     = 32'h0000_0000;
    nc     = 4'h0;
    kept   = 12'h000;
    go     = 1'b0;
    next_s = s;

    // conversion clock divider, one enable pulse per period
    tick = (s.div == 16'(CONV_DIV - 1));
    next_s.div = tick ? 16'h0000 : s.div + 16'h0001;

    // bus: first cycle captures read data, second answers
    next_s.ack = (avs_read || avs_write) && !s.ack;
    if ((avs_read || avs_write) && !s.ack) begin
      next_s.rdata = rd_word(s, avs_address);
    end
    // reading a result consumes its unread mark
    if (avs_read && s.ack && avs_address[7:5] == OFS_RES[7:5]) begin
      next_s.rvalid[avs_address[4:2]] = 1'b0;
    end
    if (avs_write && s.ack) begin
      wd = rd_word(s, avs_address);
      for (int b = 0; b < 4; b++) begin
        if (avs_byteenable[b]) wd[8*b +: 8] = avs_writedata[8*b +: 8];
      end
      if (avs_address == OFS_CTRL) begin
        next_s.en      = wd[CTRL_EN];
        next_s.auto_md = wd[CTRL_AUTO];
        next_s.cont    = wd[CTRL_CONT];
        next_s.man_ch  = wd[CTRL_CH_LO+2:CTRL_CH_LO];
        if (avs_byteenable[0] && avs_writedata[CTRL_START]) begin
          next_s.run = 1'b1;
          nc         = next_chan(s.chen, 3'h7);
          next_s.ch  = nc[2:0];
        end
      end else if (avs_address == OFS_CHEN) begin
        next_s.chen = wd[7:0];
      end else if (avs_address == OFS_STAT) begin
        if (avs_byteenable[0] && avs_writedata[STAT_DONE]) next_s.done = 1'b0;
      end else if (avs_address == OFS_LIMLO) begin
        next_s.lo = wd[11:0];
      end else if (avs_address == OFS_LIMHI) begin
        next_s.hi = wd[11:0];
      end else if (avs_address == OFS_RANGE) begin
        if (avs_byteenable[0]) next_s.rflag = s.rflag & ~avs_writedata[7:0];
      end else if (avs_address[7:5] == OFS_STIME[7:5] && avs_address[1:0] == 2'b00) begin
        next_s.stime[avs_address[4:2]] = wd[7:0];
      end
    end

    // stream buffer drain
    if (s.fcnt != 2'd0 && res_ready) begin
      next_s.fq[0] = s.fq[1];
      next_s.fcnt  = s.fcnt - 2'd1;
    end

    // sequencer
    case (s.st)
      // high-speed clock stopped: nothing runs
      S_OFF: begin
        if (!deep_sleep) begin
          next_s.st   = S_WAKE;
          next_s.wcnt = 9'(WAKE_CYC - 1);
        end
      end
      // wake-up time counted in system clocks
      S_WAKE: begin
        if (s.wcnt == 9'h000) next_s.st = S_IDLE;
        else next_s.wcnt = s.wcnt - 9'h001;
      end
      // wait for a request and room in the stream buffer
      S_IDLE: begin
        if (tick && s.run && s.en && next_s.fcnt != 2'd2 &&
            (!s.auto_md || s.chen != 8'h00)) begin
          next_s.ch   = s.auto_md ? s.ch : s.man_ch;
          next_s.scnt = samp_len(s.stime[next_s.ch]) - 8'h01;
          next_s.st   = S_SAMPLE;
        end
      end
      // acquisition window on the selected input
      S_SAMPLE: begin
        if (tick) begin
          if (s.scnt == 8'h00) begin
            next_s.st   = S_CONV;
            next_s.bitn = 4'(RES_BITS - 1);
            next_s.code = 12'h800;
          end else begin
            next_s.scnt = s.scnt - 8'h01;
          end
        end
      end
      // one trial bit per conversion clock, msb first
      S_CONV: begin
        if (tick) begin
          kept = sar_cmp ? s.code : (s.code & ~(12'h001 << s.bitn));
          if (s.bitn != 4'h0) begin
            next_s.bitn = s.bitn - 4'h1;
            next_s.code = kept | (12'h001 << (s.bitn - 4'h1));
          end else begin
            next_s.code = kept;
            next_s.res[s.ch]    = kept;
            next_s.rvalid[s.ch] = 1'b1;
            // limit check on every buffered result; set beats clear
            if (kept < s.lo || kept > s.hi) next_s.rflag[s.ch] = 1'b1;
            next_s.fq[next_s.fcnt[0]] = {s.ch, kept};
            next_s.fcnt = next_s.fcnt + 2'd1;
            if (s.auto_md) begin
              nc = next_chan(s.chen, s.ch);
              next_s.ch = nc[2:0];
              if (nc[3] || s.chen == 8'h00) begin
                next_s.done = 1'b1;
                if (!s.cont || s.chen == 8'h00) next_s.run = 1'b0;
              end
            end else begin
              next_s.done = 1'b1;
              if (!s.cont) next_s.run = 1'b0;
            end
            // chain straight into the next sample unless the buffer is full
            go = next_s.run && s.en && next_s.fcnt != 2'd2;
            if (go) begin
              if (!s.auto_md) next_s.ch = s.man_ch;
              next_s.scnt = samp_len(s.stime[next_s.ch]) - 8'h01;
              next_s.st   = S_SAMPLE;
            end else begin
              next_s.st = S_IDLE;
            end
          end
        end
      end
      default: next_s.st = S_IDLE;
    endcase

    // disable abandons a conversion in flight
    if (!s.en && (s.st == S_SAMPLE || s.st == S_CONV)) begin
      next_s.st  = S_IDLE;
      next_s.run = 1'b0;
    end
    // deep low-power mode overrides everything
    if (deep_sleep) begin
      next_s.st  = S_OFF;
      next_s.run = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s         <= '0;
      s.st      <= S_WAKE;
      s.wcnt    <= 9'(WAKE_CYC - 1);
      s.auto_md <= 1'b1;
      s.chen    <= RST_CHEN;
      s.lo      <= RST_LIMLO;
      s.hi      <= RST_LIMHI;
      s.stime   <= {NUM_CHAN{RST_STIME}};
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign avs_waitrequest = (avs_read || avs_write) && !s.ack;
  assign avs_readdata    = s.rdata;
  assign sar_ready       = (s.st != S_OFF) && (s.st != S_WAKE);
  assign sar_mux_sel     = s.ch;
  assign sar_sample      = (s.st == S_SAMPLE);
  assign sar_dac         = s.code;
  assign res_valid       = (s.fcnt != 2'd0);
  assign res_chan        = s.fq[0][14:12];
  assign res_data        = s.fq[0][11:0];
  assign scan_done_irq   = s.done;
  assign range_irq       = |s.rflag;

endmodule

`default_nettype wire

// *** shared/sar_pkg.sv ***
// Purpose: constants, register map and types of the sar channel sequencer
// Assumes: 10 MHz system clock, 32-bit avalon-mm register port
// Notes:   every register occupies one aligned word; unused bits read zero
package sar_pkg;

  // ---------------------------------------------------------------
  // converter geometry and timing
  // ---------------------------------------------------------------
  localparam int          RES_BITS     = 12;       // result width
  localparam int          NUM_CHAN     = 8;        // sequencer inputs
  localparam int          CONV_HZ_MAX  = 18000000; // highest conversion clock
  localparam int          CONV_CYC_MIN = 18;       // least clocks per result
  localparam int          MIN_SAMPLE   = CONV_CYC_MIN - RES_BITS; // floor of window
  localparam int          CLK_HZ       = 10000000; // system clock
  localparam int          WAKE_NS      = 35000;    // wake-up time, 35 us
  localparam int          WAKE_CYC     = (WAKE_NS * (CLK_HZ / 1000000) + 999) / 1000;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0]  OFS_CTRL     = 8'h00;    // enable, mode, start, channel
  localparam logic [7:0]  OFS_CHEN     = 8'h04;    // channel enable mask
  localparam logic [7:0]  OFS_STAT     = 8'h08;    // state and scan-done flag
  localparam logic [7:0]  OFS_LIMLO    = 8'h0c;    // low range limit
  localparam logic [7:0]  OFS_LIMHI    = 8'h10;    // high range limit
  localparam logic [7:0]  OFS_RANGE    = 8'h14;    // per-channel out-of-range flags
  localparam logic [7:0]  OFS_STIME    = 8'h20;    // sample time, one word per channel
  localparam logic [7:0]  OFS_RES      = 8'h40;    // result buffer, one word per channel

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int          CTRL_EN      = 0;        // block enable
  localparam int          CTRL_AUTO    = 1;        // 1 scan by state machine, 0 firmware channel
  localparam int          CTRL_CONT    = 2;        // repeat scans
  localparam int          CTRL_START   = 3;        // write 1 to start, reads zero
  localparam int          CTRL_CH_LO   = 4;        // firmware channel, bits 6:4
  localparam int          STAT_BUSY    = 0;        // sampling or converting
  localparam int          STAT_READY   = 1;        // awake and usable
  localparam int          STAT_DONE    = 2;        // scan done, write 1 to clear
  localparam int          STAT_RUN     = 3;        // scan request pending
  localparam int          STAT_FCNT_LO = 4;        // stream buffer fill, bits 5:4
  localparam int          RES_VALID    = 31;       // result unread, cleared by read

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [11:0] RST_LIMLO    = 12'h000;  // low limit
  localparam logic [11:0] RST_LIMHI    = 12'hfff;  // high limit
  localparam logic [7:0]  RST_STIME    = 8'h06;    // sample window in conversion clocks
  localparam logic [7:0]  RST_CHEN     = 8'h01;    // channel 0 only

  // sequencer states
  typedef enum logic [2:0] {
    S_OFF, S_WAKE, S_IDLE, S_SAMPLE, S_CONV
  } sar_state_t;

endpackage

// *** tb/sar_seq_properties.sv ***
// Purpose: port timing checks for the channel sequencer
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound to every sar_seq instance at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module sar_seq_chk #(
  parameter int CONV_DIV = 1  // system clocks per conversion clock
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // register bus
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic                        avs_waitrequest,
  // power and front end
  input  wire logic                        deep_sleep,
  input  wire logic                        sar_ready,
  input  wire logic [2:0]                  sar_mux_sel,
  input  wire logic                        sar_sample,
  // stream and events
  input  wire logic                        res_valid,
  input  wire logic                        res_ready,
  input  wire logic [2:0]                  res_chan,
  input  wire logic [sar_pkg::RES_BITS-1:0] res_data,
  input  wire logic                        scan_done_irq,
  input  wire logic                        range_irq
);
  import sar_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------
  // helper counters
  // ----------------
  logic [15:0] samp_cnt;  // cycles of the window under way
  logic [15:0] low_cnt;   // cycles spent not ready
  // saturation is not needed: runs stay far below 65535 cycles
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      samp_cnt <= 16'h0;
      low_cnt  <= 16'h0;
    end else begin
      samp_cnt <= sar_sample ? samp_cnt + 16'h1 : 16'h0;
      low_cnt  <= sar_ready ? 16'h0 : low_cnt + 16'h1;
    end
  end
  // ----------------
  // assertions
  // ----------------
  AST_BUS_FIRST_WAIT: assert property ($rose(avs_read) |-> avs_waitrequest)
    else $error("read not held off in its first cycle");
  AST_BUS_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer later than one cycle");
  AST_SAMPLE_MIN: assert property (
    $fell(sar_sample) && !$past(deep_sleep) |-> samp_cnt >= MIN_SAMPLE * CONV_DIV)
    else $error("sample window shorter than minimum");
  AST_SLEEP_OFF: assert property (deep_sleep |=> !sar_ready && !sar_sample)
    else $error("converter active in deep sleep");
  AST_WAKE_LEN: assert property ($rose(sar_ready) |-> low_cnt >= WAKE_CYC - 2)
    else $error("ready before wake time");
  AST_MUX_STEADY: assert property (sar_sample |=> !sar_sample || $stable(sar_mux_sel))
    else $error("channel changed in sample window");
  AST_RANGE_RESULT: assert property ($rose(range_irq) |-> res_valid)
    else $error("range request without a result");
  AST_DONE_RESULT: assert property ($rose(scan_done_irq) |-> res_valid)
    else $error("scan done without a result");
  AST_HEAD_HOLD: assert property (
    res_valid && !res_ready |=> res_valid && $stable({res_chan, res_data}))
    else $error("stream head lost while stalled");
endmodule
bind sar_seq sar_seq_chk #(.CONV_DIV(CONV_DIV)) u_chk (
  .clk(clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .deep_sleep(deep_sleep), .sar_ready(sar_ready),
  .sar_mux_sel(sar_mux_sel), .sar_sample(sar_sample), .res_valid(res_valid),
  .res_ready(res_ready), .res_chan(res_chan), .res_data(res_data),
  .scan_done_irq(scan_done_irq), .range_irq(range_irq));
`default_nettype wire

// *** tb/sar_src.sv ***
// Purpose: analog inputs and sample-and-hold feeding the comparator
// Assumes: same clock as the sequencer
// Notes:   ideal comparator, so a result equals the held level
`timescale 1ns/1ps
`default_nettype none
module sar_src (
  // clock
  input  wire logic                                     clk,
  // level of every channel, channel 0 lowest
  input  wire logic [sar_pkg::NUM_CHAN*sar_pkg::RES_BITS-1:0] lvl,
  // converter side
  input  wire logic [2:0]                               mux_sel,
  input  wire logic                                     sample,
  input  wire logic [sar_pkg::RES_BITS-1:0]             dac,
  output logic                                          cmp
);
  import sar_pkg::*;
  logic [RES_BITS-1:0] held;  // level kept on the hold capacitor
  // track the selected pin while sampling, keep it afterwards
  always_ff @(posedge clk) begin
    if (sample) begin
      held <= lvl[mux_sel*RES_BITS +: RES_BITS];
    end
  end
  assign cmp = (held >= dac);
endmodule
`default_nettype wire

// *** tb/sar_adc_channel_sequencer_test.sv ***
// Purpose: self-checking bench for the channel sequencer
// Assumes: CONV_DIV of 1 and an ideal analog source
// Notes:   waitrequest is sampled as it stands at the rising edge
`timescale 1ns/1ps
`default_nettype none
module sar_adc_channel_sequencer_test;
  import sar_pkg::*;
  // ----------------
  // signals
  // ----------------
  logic        clk, rst_n, deep_sleep, res_ready, avs_read, avs_write;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic        avs_waitrequest, sar_ready, sar_cmp, sar_sample;
  logic        res_valid, scan_done_irq, range_irq;
  logic [2:0]  sar_mux_sel, res_chan;
  logic [11:0] sar_dac, res_data;
  logic [95:0] lvl;           // analog level of each channel
  logic [14:0] got [$];       // words taken from the stream
  int          num_errors, total_checks, rises, slen, n, n1;
  int          win [8];       // last window length per channel
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  sar_seq #(.CONV_DIV(1)) dut (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .deep_sleep(deep_sleep), .sar_ready(sar_ready), .sar_cmp(sar_cmp),
    .sar_mux_sel(sar_mux_sel), .sar_sample(sar_sample), .sar_dac(sar_dac),
    .res_valid(res_valid), .res_ready(res_ready), .res_chan(res_chan),
    .res_data(res_data), .scan_done_irq(scan_done_irq), .range_irq(range_irq));
  sar_src src (.clk(clk), .lvl(lvl), .mux_sel(sar_mux_sel), .sample(sar_sample),
    .dac(sar_dac), .cmp(sar_cmp));
  // measure sample windows and collect stream words
  always @(posedge clk) begin
    if (sar_sample) begin
      if (slen == 0) rises++;
      slen++;
    end else if (slen != 0) begin
      win[sar_mux_sel] = slen;
      slen = 0;
    end
    if (res_valid && res_ready) got.push_back({res_chan, res_data});
  end
  // ----------------
  // tasks
  // ----------------
  task automatic eq(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one bus access; the request stands until waitrequest is low at an edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ws;
    int   k;
    k = 0;
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      ws = avs_waitrequest;
      q = avs_readdata;
      k++;
    end while (ws !== 1'b0 && k < 50);
    if (ws !== 1'b0) num_errors++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    eq(q & m, e);
  endtask
  task automatic wt(input int c);
    n = 0;
    while (scan_done_irq !== 1'b1 && n < c) begin
      @(negedge clk);
      n++;
    end
    if (scan_done_irq !== 1'b1) num_errors++;
  endtask
  task automatic rdy;
    n = 0;
    while (sar_ready !== 1'b1 && n < 600) begin
      @(negedge clk);
      n++;
    end
  endtask
  // poll until nothing runs, then clear the done flag
  task automatic idle;
    int k;
    k = 0;
    do begin
      acc(1'b0, OFS_STAT, 32'h0);
      k++;
    end while ((q[STAT_BUSY] | q[STAT_RUN]) !== 1'b0 && k < 100);
    if ((q[STAT_BUSY] | q[STAT_RUN]) !== 1'b0) num_errors++;
    acc(1'b1, OFS_STAT, 32'h4);
  endtask
  task automatic stream_chk(input int k);
    for (int c = 0; c < k; c++) eq(got[c], {3'(c), lvl[c*12 +: 12]});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ----------------
  // tests
  // ----------------
  initial begin
    rst_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata, deep_sleep} = '0;
    res_ready = 1'b1;
    lvl = {12'hfff, 12'h000, 12'h555, 12'habc, 12'h801, 12'h800, 12'h100, 12'h0ff};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdy();
    eq(n >= 345 && n <= 356, 32'h1);
    chk(OFS_CTRL, 32'h7f, 32'h02);
    chk(OFS_CHEN, 32'hffffffff, 32'h01);
    chk(OFS_LIMHI, 32'hffffffff, 32'hfff);
    chk(OFS_STIME + 8'h1c, 32'hffffffff, 32'h06);
    acc(1'b1, 8'h18, 32'hffffffff);
    chk(8'h18, 32'hffffffff, 32'h0);
    // full scan of four channels against limits 0x100..0x800
    acc(1'b1, OFS_LIMLO, 32'h100);
    acc(1'b1, OFS_LIMHI, 32'h800);
    acc(1'b1, OFS_CHEN, 32'h0f);
    acc(1'b1, OFS_CTRL, 32'h0b);
    wt(1000);
    for (int c = 0; c < 4; c++) begin
      chk(OFS_RES + 8'(4*c), 32'h80000fff, {20'h80000, lvl[c*12 +: 12]});
      chk(OFS_RES + 8'(4*c), 32'h80000000, 32'h0);
    end
    stream_chk(4);
    chk(OFS_RANGE, 32'hff, 32'h09);
    eq({31'h0, range_irq}, 32'h1);
    chk(OFS_STAT, 32'h04, 32'h04);
    acc(1'b1, OFS_STAT, 32'h4);
    acc(1'b1, OFS_RANGE, 32'hff);
    @(negedge clk);
    eq({30'h0, scan_done_irq, range_irq}, 32'h0);
    // per-channel windows, one below the floor
    acc(1'b1, OFS_STIME + 8'h4, 32'h14);
    acc(1'b1, OFS_STIME + 8'h8, 32'h2);
    acc(1'b1, OFS_CHEN, 32'h06);
    acc(1'b1, OFS_CTRL, 32'h0b);
    wt(1000);
    eq(win[1], 32'h14);
    eq(win[2], 32'h6);
    idle();
    // windows per unit time: one channel against three
    acc(1'b1, OFS_STIME + 8'h4, 32'h6);
    acc(1'b1, OFS_CHEN, 32'h01);
    rises = 0;
    acc(1'b1, OFS_CTRL, 32'h0f);
    repeat (300) @(negedge clk);
    n1 = rises;
    acc(1'b1, OFS_CTRL, 32'h03);
    idle();
    acc(1'b1, OFS_CHEN, 32'h0e);
    rises = 0;
    acc(1'b1, OFS_CTRL, 32'h0f);
    repeat (300) @(negedge clk);
    eq(rises, n1);
    acc(1'b1, OFS_CTRL, 32'h03);
    idle();
    // firmware picks channel 5
    got.delete();
    acc(1'b1, OFS_CTRL, 32'h59);
    wt(300);
    chk(OFS_RES + 8'h14, 32'h80000fff, 32'h80000555);
    eq(got[0], {3'h5, 12'h555});
    idle();
    // stalled receiver: two words held, none lost
    got.delete();
    res_ready <= 1'b0;
    acc(1'b1, OFS_CHEN, 32'h0f);
    acc(1'b1, OFS_CTRL, 32'h0b);
    repeat (150) @(negedge clk);
    chk(OFS_STAT, 32'h30, 32'h20);
    eq(got.size(), 32'h0);
    res_ready <= 1'b1;
    wt(1000);
    // the last word is pushed with the done flag and popped one edge later
    @(negedge clk);
    eq(got.size(), 32'h4);
    stream_chk(4);
    idle();
    // deep sleep stops the converter, then the wake time runs
    deep_sleep <= 1'b1;
    repeat (3) @(negedge clk);
    eq({31'h0, sar_ready}, 32'h0);
    @(posedge clk);
    deep_sleep <= 1'b0;
    rdy();
    eq(n >= 345 && n <= 356, 32'h1);
    tally_and_finish();
  end
  // cut a hang short
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
